// >>> uhtc_cfg.svh
`ifndef UHTC_CFG_SVH
`define UHTC_CFG_SVH
// register byte addresses
`define UHTC_CTRL_ADDR 12'h000
`define UHTC_COUNT_ADDR 12'h004
`define UHTC_PERIOD_ADDR 12'h008
`define UHTC_STATUS_ADDR 12'h00C
`define UHTC_MASK_ADDR 12'h010
`define UHTC_LOWER_ADDR 12'h014
// control field positions
`define UHTC_RUN_BIT 15
`define UHTC_SIDL_BIT 13
`define UHTC_GATE_BIT 6
`define UHTC_PS_HI 5
`define UHTC_PS_LO 4
`define UHTC_CS_BIT 1
// writable bits of the control word
`define UHTC_CTRL_MASK 16'hA072
// reset values
`define UHTC_CTRL_RST 16'h0000
`define UHTC_PERIOD_RST 16'hFFFF
// prescale terminal counts (divide minus one)
`define UHTC_DIV1 8'h00
`define UHTC_DIV8 8'h07
`define UHTC_DIV64 8'h3F
`define UHTC_DIV256 8'hFF
`endif

// >>> uhtc_pkg.sv
package uhtc_pkg;
  // prescale codes
  typedef enum logic [1:0]
  {
    UHTC_PS_1 = 2'b00,
    UHTC_PS_8 = 2'b01,
    UHTC_PS_64 = 2'b10,
    UHTC_PS_256 = 2'b11
  } uhtc_ps_t;
  // ahb slave phase
  typedef enum logic [1:0]
  {
    UHTC_IDLE = 2'b00,
    UHTC_WR = 2'b01,
    UHTC_RD = 2'b11
  } uhtc_bus_t;
endpackage : uhtc_pkg

// >>> uhtc_tick.sv
`timescale 1ns/1ns
`include "uhtc_cfg.svh"
// tick source: pin sync, edge detect, gate and prescaler
module uhtc_tick
  import uhtc_pkg::*;
#(
  parameter bit HAS_PIN = 1'b1
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // configuration
  input wire logic enable,
  input wire logic ext_sel,
  input wire logic gate_en,
  input wire uhtc_pkg::uhtc_ps_t ps,
  // pin
  input wire logic ext_pin,
  // count tick
  output logic tick
);
  // two-stage synchroniser plus history for edge detect
  logic s1_r, s2_r, s3_r;
  logic [7:0] pre_r, pre_nxt;
  logic tick_r, tick_nxt;
  logic [7:0] term;
  logic src;

  ////////////////////////////////////////////////////////////////////////
  // input clock select and prescaler next state
  always_comb
  begin
    unique case (ps)
      UHTC_PS_1: term = `UHTC_DIV1;
      UHTC_PS_8: term = `UHTC_DIV8;
      UHTC_PS_64: term = `UHTC_DIV64;
      UHTC_PS_256: term = `UHTC_DIV256;
    endcase
    // no pin on this instance: only the internal source exists
    if (HAS_PIN && ext_sel)
      src = s2_r & ~s3_r;
    else if (gate_en) // gate ignored in external mode
      src = s2_r;
    else
      src = 1'b1;
    pre_nxt = pre_r;
    tick_nxt = 1'b0;
    if (!enable)
      pre_nxt = pre_r; // hold prescaler state while halted
    else if (src)
    begin
      if (pre_r >= term)
      begin
        pre_nxt = 8'h00;
        tick_nxt = 1'b1;
      end
      else
        pre_nxt = pre_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      pre_r <= 8'h00;
      tick_r <= 1'b0;
    end
    else
    begin
      s1_r <= ext_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      pre_r <= pre_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;
endmodule : uhtc_tick

// >>> uhtc_top.sv
// Operation
// - stop in idle when stop-in-idle set
// - gate pin qualifies internal counting only
// - prescale 1, 8, 64, 256
// - source select external pin rising edges
// - unimplemented control bits read zero
// - external pin optional per instance
// - upper count holds the high word
// - lower timer controls pair, match is ours
//
// Design decisions made here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "uhtc_cfg.svh"
module uhtc_top
  import uhtc_pkg::*;
#(
  parameter bit HAS_PIN = 1'b1
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // device state and pair link
  input wire logic idle_mode,
  input wire logic pair_join,
  input wire logic lower_carry,
  // external clock or gate pin
  input wire logic ext_pin,
  // interrupt
  output logic irq
);
  import uhtc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [15:0] ctrl_r, ctrl_nxt; // control word
  logic [15:0] cnt_r, cnt_nxt; // upper count word
  logic [15:0] per_r, per_nxt; // period
  logic [15:0] lowc_r, lowc_nxt; // lower control mirror
  logic [0:0] stat_r, stat_nxt; // match status, sticky
  logic [0:0] mask_r, mask_nxt; // interrupt mask
  logic [31:0] rd_r, rd_nxt;
  logic irq_r, irq_nxt;
  uhtc_bus_t ph_r, ph_nxt;
  logic [11:0] ad_r, ad_nxt;
  logic run_ok, tick, step, match, rd_stat;
  logic lj1_r, lj2_r, lc1_r, lc2_r, id1_r, id2_r; // pin-side syncs
  logic [15:0] src_ctl;

  ////////////////////////////////////////////////////////////////////////
  // in pair mode the lower control word drives the prescaler and run
  always_comb
  begin
    src_ctl = lj2_r ? lowc_r : ctrl_r;
    run_ok = src_ctl[`UHTC_RUN_BIT]
      && !(id2_r && ctrl_r[`UHTC_SIDL_BIT]);
  end

  // tick generator
  uhtc_tick #(.HAS_PIN(HAS_PIN)) u_tick
  (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .enable(run_ok),
    .ext_sel(src_ctl[`UHTC_CS_BIT]),
    .gate_en(src_ctl[`UHTC_GATE_BIT]),
    .ps(uhtc_ps_t'(src_ctl[`UHTC_PS_HI:`UHTC_PS_LO])),
    .ext_pin(ext_pin),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // counting: alone on our tick, joined on the lower word's carry
  always_comb
  begin
    step = lj2_r ? (lc2_r && run_ok) : (tick && run_ok);
    match = step && (cnt_r == per_r);
    cnt_nxt = cnt_r;
    if (match)
      cnt_nxt = 16'h0000;
    else if (step)
      cnt_nxt = cnt_r + 16'h0001; // held when not stepping
  end

  ////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states, always okay
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    per_nxt = per_r;
    lowc_nxt = lowc_r;
    mask_nxt = mask_r;
    rd_nxt = rd_r;
    ph_nxt = UHTC_IDLE;
    ad_nxt = ad_r;
    rd_stat = 1'b0;
    if (hsel && hready && htrans[1])
    begin
      ad_nxt = haddr;
      ph_nxt = hwrite ? UHTC_WR : UHTC_RD;
      unique case (haddr)
        `UHTC_CTRL_ADDR: rd_nxt = {16'h0000, ctrl_r};
        `UHTC_COUNT_ADDR: rd_nxt = {16'h0000, cnt_r};
        `UHTC_PERIOD_ADDR: rd_nxt = {16'h0000, per_r};
        `UHTC_STATUS_ADDR: rd_nxt = {31'h0000_0000, stat_r};
        `UHTC_MASK_ADDR: rd_nxt = {31'h0000_0000, mask_r};
        `UHTC_LOWER_ADDR: rd_nxt = {16'h0000, lowc_r};
        default: rd_nxt = 32'h0000_0000;
      endcase
      rd_stat = !hwrite && (haddr == `UHTC_STATUS_ADDR);
    end
    if (ph_r == UHTC_WR)
    begin
      unique case (ad_r)
        `UHTC_CTRL_ADDR: ctrl_nxt = hwdata[15:0] & `UHTC_CTRL_MASK;
        `UHTC_PERIOD_ADDR: per_nxt = hwdata[15:0];
        `UHTC_MASK_ADDR: mask_nxt = hwdata[0:0];
        `UHTC_LOWER_ADDR: lowc_nxt = hwdata[15:0];
        default: ;
      endcase
    end
    // a match in the clearing read's cycle wins
    stat_nxt = rd_stat ? 1'b0 : stat_r;
    if (match)
      stat_nxt = 1'b1;
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  ////////////////////////////////////////////////////////////////////////
  // counting write from bus takes precedence over a tick
  logic [15:0] cnt_fin;
  logic cnt_wr; // bus write to the count word in this data phase
  always_comb
  begin
    cnt_wr = (ph_r == UHTC_WR) && (ad_r == `UHTC_COUNT_ADDR);
    cnt_fin = cnt_nxt;
    if (cnt_wr)
      cnt_fin = hwdata[15:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_r <= `UHTC_CTRL_RST;
      cnt_r <= 16'h0000;
      per_r <= `UHTC_PERIOD_RST;
      lowc_r <= 16'h0000;
      stat_r <= 1'b0;
      mask_r <= 1'b0;
      rd_r <= 32'h0000_0000;
      irq_r <= 1'b0;
      ph_r <= UHTC_IDLE;
      ad_r <= 12'h000;
      lj1_r <= 1'b0;
      lj2_r <= 1'b0;
      lc1_r <= 1'b0;
      lc2_r <= 1'b0;
      id1_r <= 1'b0;
      id2_r <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      cnt_r <= cnt_fin;
      per_r <= per_nxt;
      lowc_r <= lowc_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      rd_r <= rd_nxt;
      irq_r <= irq_nxt;
      ph_r <= ph_nxt;
      ad_r <= ad_nxt;
      lj1_r <= pair_join;
      lj2_r <= lj1_r;
      lc1_r <= lower_carry;
      lc2_r <= lc1_r;
      id1_r <= idle_mode;
      id2_r <= id1_r;
    end
  end

  assign hrdata = rd_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence halted_s;
    !ctrl_r[`UHTC_RUN_BIT] && !lj2_r && !(ph_r == UHTC_WR);
  endsequence
  // idle with stop set, and no bus write to the count word pending
  sequence idle_stopped_s;
    id2_r && ctrl_r[`UHTC_SIDL_BIT] && !cnt_wr;
  endsequence
  // a plain step: no wrap at the period, no bus overwrite
  sequence stepping_s;
    step && !match && !cnt_wr;
  endsequence
  run_hold_a: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    halted_s |=> cnt_r == $past(cnt_r))
    else $error("count moved while halted");
  idle_stop_a: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    idle_stopped_s |=> cnt_r == $past(cnt_r))
    else $error("counting in idle with stop set");
  ctrl_zero_a: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (ctrl_r & ~`UHTC_CTRL_MASK) == 16'h0000)
    else $error("unimplemented control bit set");
  irq_lvl_a: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    irq_r == |(stat_r & mask_r))
    else $error("irq not tracking status");
  step_count_a: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    stepping_s |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("count did not advance on a step");
  // a clearing read in the same cycle must not hide the match
  match_set_a: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    match |=> stat_r[0])
    else $error("period match not latched");
endmodule : uhtc_top

// >>> uhtc_pin_model.sv
`timescale 1ns/1ns
// far side: external clock or gate pin
module uhtc_pin_model
(
  // clock
  input wire logic core_clk,
  // bench control
  input wire logic clk_on,
  input wire logic lvl,
  // pin
  output logic ext_pin
);
  // half period counter, pin clock is core clock over ten
  logic [2:0] cnt_r = 3'h0;
  initial ext_pin = 1'b0;
  // pin stands at lvl between bursts so no stray edges leak in
  always @(posedge core_clk)
  begin
    if (!clk_on)
    begin
      cnt_r <= 3'h0;
      ext_pin <= lvl;
    end
    else if (cnt_r == 3'h4)
    begin
      cnt_r <= 3'h0;
      ext_pin <= !ext_pin;
    end
    else
      cnt_r <= cnt_r + 3'h1;
  end
endmodule : uhtc_pin_model

// >>> upper_half_timer_control_tb_top.sv
`timescale 1ns/1ns
`include "uhtc_cfg.svh"
module upper_half_timer_control_tb_top;
  import uhtc_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, irq, ext_pin;
  logic idle_mode, pair_join, lower_carry, clk_on, lvl;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, q, hrdata_np, q_np;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  int div[4] = '{1, 8, 64, 256};
  always #10 core_clk = ~core_clk;
  // hready is fed back from u_dut, the first of the two slaves
  uhtc_top u_dut (.core_clk(core_clk), .arst_n(arst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .idle_mode(idle_mode),
    .pair_join(pair_join), .lower_carry(lower_carry), .ext_pin(ext_pin),
    .irq(irq));
  uhtc_pin_model u_pin (.core_clk(core_clk), .clk_on(clk_on), .lvl(lvl),
    .ext_pin(ext_pin));
  // pin-less copy on the same bus: its source select must be inert
  uhtc_top #(.HAS_PIN(1'b0)) u_dut_np (.core_clk(core_clk),
    .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata_np), .hreadyout(), .hresp(), .idle_mode(idle_mode),
    .pair_join(pair_join), .lower_carry(lower_carry), .ext_pin(ext_pin),
    .irq());
  //////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize
  // range compare; an unknown never falls inside the range
  task automatic chk(input logic [15:0] got, input int lo, input int hi);
    compares++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      n_mismatch++;
      $display("unexpected t=%0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask : chk
  // one ahb-lite single transfer, read data lands in q
  task automatic bus(input logic [11:0] a, input logic w,
    input logic [15:0] wd);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'b010;
    htrans <= 2'b10;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {16'h0000, wd};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    q = hrdata;
    q_np = hrdata_np;
    chk({15'h0000, hresp}, 0, 0);
  endtask : bus
  // run with a control word for w cycles, judge the count gained
  task automatic run_for(input logic [15:0] ctl, input int w,
    input logic burst, input int lo, input int hi);
    logic [15:0] c0;
    bus(`UHTC_COUNT_ADDR, 1'b0, 16'h0000);
    c0 = q[15:0];
    bus(`UHTC_CTRL_ADDR, 1'b1, ctl);
    clk_on <= burst;
    repeat (w) @(posedge core_clk);
    clk_on <= 1'b0;
    if (burst)
      repeat (8) @(posedge core_clk);
    bus(`UHTC_CTRL_ADDR, 1'b1, ctl & 16'h7FFF);
    bus(`UHTC_COUNT_ADDR, 1'b0, 16'h0000);
    chk(q[15:0] - c0, lo, hi);
    c0 = q[15:0];
    repeat (20) @(posedge core_clk);
    bus(`UHTC_COUNT_ADDR, 1'b0, 16'h0000);
    chk(q[15:0], c0, c0);
  endtask : run_for
  //////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    bus(`UHTC_CTRL_ADDR, 1'b0, 16'h0000);
    chk(q[15:0], 0, 0);
    bus(`UHTC_CTRL_ADDR, 1'b1, 16'hFFFF);
    bus(`UHTC_CTRL_ADDR, 1'b0, 16'h0000);
    chk(q[15:0], 16'hA072, 16'hA072);
    bus(`UHTC_CTRL_ADDR, 1'b1, 16'h0000);
    bus(12'h800, 1'b0, 16'h0000);
    chk(q[15:0], 0, 0);
  endtask : t_regs
  // short period so the match fires, masked and unmasked
  task automatic t_irq();
    bus(`UHTC_PERIOD_ADDR, 1'b1, 16'h0009);
    for (int m = 1; m >= 0; m--)
    begin
      bus(`UHTC_MASK_ADDR, 1'b1, 16'(m));
      bus(`UHTC_CTRL_ADDR, 1'b1, 16'h8000);
      repeat (30) @(posedge core_clk);
      bus(`UHTC_CTRL_ADDR, 1'b1, 16'h0000);
      chk({15'h0000, irq}, m, m);
      bus(`UHTC_STATUS_ADDR, 1'b0, 16'h0000);
      chk(q[15:0], 1, 1);
      repeat (3) @(posedge core_clk);
      chk({15'h0000, irq}, 0, 0);
    end
    bus(`UHTC_STATUS_ADDR, 1'b0, 16'h0000);
    chk(q[15:0], 0, 0);
    bus(`UHTC_PERIOD_ADDR, 1'b1, 16'hFFFF);
  endtask : t_irq
  task automatic t_scale();
    for (int k = 0; k < 4; k++)
      run_for(16'h8000 | 16'(k << 4), 40 * div[k], 1'b0, 38, 44);
  endtask : t_scale
  task automatic t_idle();
    idle_mode <= 1'b1;
    run_for(16'hA000, 40, 1'b0, 0, 0);
    run_for(16'h8000, 40, 1'b0, 38, 44);
    idle_mode <= 1'b0;
  endtask : t_idle
  task automatic t_pin();
    logic [15:0] c_np;
    run_for(16'h8040, 40, 1'b0, 0, 0);
    lvl <= 1'b1;
    run_for(16'h8040, 40, 1'b0, 38, 44);
    run_for(16'h8042, 40, 1'b0, 0, 0);
    lvl <= 1'b0;
    bus(`UHTC_COUNT_ADDR, 1'b0, 16'h0000);
    c_np = q_np[15:0];
    run_for(16'h8002, 100, 1'b1, 10, 10);
    // the pin-less copy ignores the source select and counts every cycle
    chk(q_np[15:0] - c_np, 108, 112);
  endtask : t_pin
  // joined pair: steps come only from the lower half's carry
  task automatic t_pair();
    logic [15:0] c0;
    pair_join <= 1'b1;
    idle_mode <= 1'b1;
    bus(`UHTC_LOWER_ADDR, 1'b1, 16'h8000);
    // in idle the pair keeps running only with our stop field clear
    for (int s = 0; s < 2; s++)
    begin
      bus(`UHTC_CTRL_ADDR, 1'b1, 16'(s << 13));
      bus(`UHTC_COUNT_ADDR, 1'b0, 16'h0000);
      c0 = q[15:0];
      repeat (5)
      begin
        lower_carry <= 1'b1;
        @(posedge core_clk);
        lower_carry <= 1'b0;
        repeat (4) @(posedge core_clk);
      end
      bus(`UHTC_COUNT_ADDR, 1'b0, 16'h0000);
      chk(q[15:0] - c0, 5 - 5 * s, 5 - 5 * s);
    end
    bus(`UHTC_LOWER_ADDR, 1'b1, 16'h0000);
    pair_join <= 1'b0;
    idle_mode <= 1'b0;
  endtask : t_pair
  //////////////////////////////////////////////////////////////////////////
  // hang guard, the whole run needs about 14000 cycles
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_mismatch++;
      summarize();
    end
  end
  initial
  begin
    {hsel, hwrite, idle_mode, pair_join, lower_carry, clk_on, lvl} = 7'h00;
    haddr = 12'h000;
    htrans = 2'b00;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    t_regs();
    t_irq();
    t_scale();
    t_idle();
    t_pin();
    t_pair();
    summarize();
  end
endmodule : upper_half_timer_control_tb_top
